/* include/spcg_pkg.sv */
// constants for the serial port control and gating block
package spcg_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_FMT = 8'h04;
   localparam logic [7:0] ADDR_FLAGS = 8'h08;
   localparam logic [7:0] ADDR_TXBUF = 8'h0c;
   localparam logic [7:0] ADDR_RXBUF = 8'h10;
   // reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] FMT_RST = 8'h00;
   localparam logic [7:0] FLAGS_RST = 8'h84;
   localparam logic [7:0] TXBUF_RST = 8'hff;
   localparam logic [7:0] RXBUF_RST = 8'h00;
   // control register fields
   localparam int CTL_TX_EMPTY_IRQ_EN = 7;
   localparam int CTL_RX_IRQ_EN = 6;
   localparam int CTL_TX_ENABLE = 5;
   localparam int CTL_RX_ENABLE = 4;
   localparam int CTL_MULTIPROC_FILTER_EN = 3;
   localparam int CTL_TX_DONE_IRQ_EN = 2;
   localparam int CTL_CLK_SRC_EXT_SEL = 1;
   localparam int CTL_CLK_PIN_OUT_SEL = 0;
   // frame format register fields
   localparam int FMT_SYNC_MODE = 7;
   localparam int FMT_MULTIPROC_FORMAT_SEL = 2;
   // flag register fields
   localparam int FLG_TX_BUF_EMPTY = 7;
   localparam int FLG_RX_FULL = 6;
   localparam int FLG_OVERRUN_ERR = 5;
   localparam int FLG_FRAMING_ERR = 4;
   localparam int FLG_PARITY_ERR = 3;
   localparam int FLG_TX_DONE = 2;
   localparam int FLG_MULTIPROC_BIT = 1;
   localparam int FLG_MULTIPROC_BIT_TX = 0;
   // flags that clear only by writing 0 after reading 1
   localparam logic [7:0] FLG_CLR_MASK = 8'hf8;
   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   // default half period of the internal bit clock, in system clocks
   localparam int HALF_BIT_CYC = 4;
endpackage : spcg_pkg

/* rtl/spcg_top.sv */
// serial port control, flag gating, interrupt gating and clock pin role
// Functional notes
// - control register clears to zero on reset, standby or module stop
// - all control bits readable and writable at any time; writes are ignored while standby or module stop is asserted
// - tx-empty request while its enable and tx buffer empty flag set
// - tx-empty request drops on read-1-then-clear or enable clear
// - rx interrupt enable gates both rx-full and rx-error requests
// - rx requests drop on flag read-1-then-clear or enable clear
// - tx buffer empty flag held at one while tx disabled
// - transmission starts after buffer written and empty flag cleared
// - clearing rx enable leaves rx flags unchanged
// - rx begins on start bit (async), incoming clock (sync external clock) or tx go (sync internal clock)
// - multiprocessor filter only in async mode with multiproc format
// - filtered character with mp bit zero is dropped silently
// - mp bit one sets mp flag and clears filter enable
// - tx-done request gated by its enable; raised after last bit
// - tx-done request drops on flag clears or enable clear
// - clock pin output select honoured only in async internal clock
// - async internal: pin is port, or outputs bit-rate clock
// - external clock selected: pin is input clock
// - sync internal: pin drives the serial bit clock
// - format mode bit: zero async, one clocked synchronous
// - rx-full flag set when an error-free received character moves to rx buffer
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module spcg_top
   import spcg_pkg::*;
#(
   parameter int HALF_BIT = spcg_pkg::HALF_BIT_CYC
)
(
   input wire logic I_REF_CLK,
   input wire logic I_RST_B,
   input wire logic I_STANDBY,
   input wire logic I_MODULE_STOP,
   // AXI4-Lite slave
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // shifter datapath events
   input wire logic I_TX_LOAD,
   input wire logic I_TX_LAST_BIT,
   input wire logic I_RX_DONE,
   input wire logic [7:0] I_RX_DATA,
   input wire logic I_RX_MPB,
   input wire logic I_RX_FRAME_ERR,
   input wire logic I_RX_PARITY_ERR,
   output logic O_TX_GO,
   output logic [7:0] O_TX_DATA,
   output logic O_RX_BEGIN,
   output logic O_EXT_CLK_EDGE,
   // pins
   input wire logic I_RXD,
   input wire logic I_SCK_I,
   output logic O_SCK_O,
   output logic O_SCK_OE,
   output logic O_SCK_GPIO,
   // interrupt requests
   output logic O_TX_EMPTY_IRQ,
   output logic O_RX_FULL_IRQ,
   output logic O_RX_ERR_IRQ,
   output logic O_TX_DONE_IRQ
);
   initial
   begin
      if (HALF_BIT < 1 || HALF_BIT > 65535)
      begin
         $error("HALF_BIT out of range");
      end
   end

   logic [7:0] ctrl_q;
   logic [7:0] ctrl_d;
   logic [7:0] fmt_q;
   logic [7:0] flags_q;
   logic [7:0] flags_d;
   logic [7:0] arm_q;
   logic [7:0] tx_buf_q;
   logic [7:0] rx_buf_q;
   logic mod_clr;
   assign mod_clr = I_STANDBY | I_MODULE_STOP;

   // ---------------- bus slave ----------------
   logic aw_have_q;
   logic w_have_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;

   logic aw_fire;
   logic w_fire;
   logic wr_fire;
   logic ar_fire;
   assign S_AXI_AWREADY = !aw_have_q && !bvalid_q;
   assign S_AXI_WREADY = !w_have_q && !bvalid_q;
   assign S_AXI_ARREADY = !rvalid_q;
   assign aw_fire = S_AXI_AWVALID && S_AXI_AWREADY;
   assign w_fire = S_AXI_WVALID && S_AXI_WREADY;
   assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
   assign ar_fire = S_AXI_ARVALID && S_AXI_ARREADY;

   logic wr_ctrl;
   logic wr_fmt;
   logic wr_flags;
   logic wr_txbuf;
   logic wr_hit;
   logic wr_b0;
   logic [7:0] wbyte;
   assign wr_b0 = wr_fire && wstrb_q[0];
   assign wbyte = wdata_q[7:0];
   assign wr_ctrl = wr_b0 && (awaddr_q == ADDR_CTRL);
   assign wr_fmt = wr_b0 && (awaddr_q == ADDR_FMT);
   assign wr_flags = wr_b0 && (awaddr_q == ADDR_FLAGS);
   assign wr_txbuf = wr_b0 && (awaddr_q == ADDR_TXBUF);
   assign wr_hit = (awaddr_q == ADDR_CTRL) || (awaddr_q == ADDR_FMT) ||
      (awaddr_q == ADDR_FLAGS) || (awaddr_q == ADDR_TXBUF) ||
      (awaddr_q == ADDR_RXBUF);

   logic rd_hit;
   logic rd_flags;
   logic [7:0] rd_byte;
   assign rd_flags = ar_fire && (S_AXI_ARADDR == ADDR_FLAGS);
   assign rd_hit = (S_AXI_ARADDR == ADDR_CTRL) ||
      (S_AXI_ARADDR == ADDR_FMT) || (S_AXI_ARADDR == ADDR_FLAGS) ||
      (S_AXI_ARADDR == ADDR_TXBUF) || (S_AXI_ARADDR == ADDR_RXBUF);
   assign rd_byte =
      (S_AXI_ARADDR == ADDR_CTRL) ? ctrl_q :
      (S_AXI_ARADDR == ADDR_FMT) ? fmt_q :
      (S_AXI_ARADDR == ADDR_FLAGS) ? flags_q :
      (S_AXI_ARADDR == ADDR_TXBUF) ? tx_buf_q :
      (S_AXI_ARADDR == ADDR_RXBUF) ? rx_buf_q : 8'h00;

   always_ff @(posedge I_REF_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         aw_have_q <= 1'b0;
         awaddr_q <= 8'h00;
      end
      else if (aw_fire)
      begin
         aw_have_q <= 1'b1;
         awaddr_q <= S_AXI_AWADDR;
      end
      else if (wr_fire)
      begin
         aw_have_q <= 1'b0;
      end
   end

   always_ff @(posedge I_REF_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         w_have_q <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end
      else if (w_fire)
      begin
         w_have_q <= 1'b1;
         wdata_q <= S_AXI_WDATA;
         wstrb_q <= S_AXI_WSTRB;
      end
      else if (wr_fire)
      begin
         w_have_q <= 1'b0;
      end
   end

   always_ff @(posedge I_REF_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end
      else if (wr_fire)
      begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_hit ? RESP_OKAY : RESP_DECERR;
      end
      else if (S_AXI_BREADY)
      begin
         bvalid_q <= 1'b0;
      end
   end

   always_ff @(posedge I_REF_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= RESP_OKAY;
      end
      else if (ar_fire)
      begin
         rvalid_q <= 1'b1;
         rdata_q <= {24'h00_0000, rd_byte};
         rresp_q <= rd_hit ? RESP_OKAY : RESP_DECERR;
      end
      else if (S_AXI_RREADY)
      begin
         rvalid_q <= 1'b0;
      end
   end

   assign S_AXI_BVALID = bvalid_q;
   assign S_AXI_BRESP = bresp_q;
   assign S_AXI_RVALID = rvalid_q;
   assign S_AXI_RDATA = rdata_q;
   assign S_AXI_RRESP = rresp_q;

   // ---------------- mode decode ----------------
   logic sync_mode;
   logic mp_fmt;
   logic ext_clk;
   logic tx_en;
   logic rx_en;
   logic mpf_active;
   assign sync_mode = fmt_q[FMT_SYNC_MODE];
   assign mp_fmt = fmt_q[FMT_MULTIPROC_FORMAT_SEL] && !sync_mode;
   assign ext_clk = ctrl_q[CTL_CLK_SRC_EXT_SEL];
   assign tx_en = ctrl_q[CTL_TX_ENABLE];
   assign rx_en = ctrl_q[CTL_RX_ENABLE];
   assign mpf_active = mp_fmt && ctrl_q[CTL_MULTIPROC_FILTER_EN];

   // ---------------- receive event handling ----------------
   logic rx_evt;
   logic rx_acc;
   logic rx_ovr;
   logic rx_fer;
   logic rx_per;
   logic rx_good;
   logic mp_wake;
   assign rx_evt = I_RX_DONE && rx_en;
   assign rx_acc = rx_evt && !(mpf_active && !I_RX_MPB);
   assign mp_wake = rx_evt && mpf_active && I_RX_MPB;
   assign rx_ovr = rx_acc && flags_q[FLG_RX_FULL];
   assign rx_fer = rx_acc && !rx_ovr && I_RX_FRAME_ERR && !sync_mode;
   assign rx_per = rx_acc && !rx_ovr && I_RX_PARITY_ERR && !sync_mode &&
      !mp_fmt;
   assign rx_good = rx_acc && !rx_ovr && !rx_fer && !rx_per;

   // ---------------- control register ----------------
   always_comb
   begin
      ctrl_d = ctrl_q;
      if (wr_ctrl)
      begin
         ctrl_d = wbyte;
      end
      if (mp_wake)
      begin
         ctrl_d[CTL_MULTIPROC_FILTER_EN] = 1'b0;
      end
   end

   always_ff @(posedge I_REF_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         ctrl_q <= CTRL_RST;
         fmt_q <= FMT_RST;
         tx_buf_q <= TXBUF_RST;
      end
      else if (mod_clr)
      begin
         ctrl_q <= CTRL_RST;
         fmt_q <= FMT_RST;
         tx_buf_q <= TXBUF_RST;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         fmt_q <= wr_fmt ? wbyte : fmt_q;
         tx_buf_q <= wr_txbuf ? wbyte : tx_buf_q;
      end
   end

   // ---------------- status flags ----------------
   logic [7:0] sw_clr;
   logic [7:0] hw_set;
   logic [7:0] hw_clr;
   // clear only flags read as one beforehand and now written zero
   assign sw_clr = {8{wr_flags}} & ~wbyte & arm_q & FLG_CLR_MASK;

   assign hw_set[FLG_TX_BUF_EMPTY] = !tx_en || I_TX_LOAD;
   assign hw_set[FLG_RX_FULL] = rx_good;
   assign hw_set[FLG_OVERRUN_ERR] = rx_ovr;
   assign hw_set[FLG_FRAMING_ERR] = rx_fer;
   assign hw_set[FLG_PARITY_ERR] = rx_per;
   assign hw_set[FLG_TX_DONE] = I_TX_LAST_BIT &&
      flags_q[FLG_TX_BUF_EMPTY];
   assign hw_set[FLG_MULTIPROC_BIT] = rx_acc && mp_fmt && I_RX_MPB;
   assign hw_set[FLG_MULTIPROC_BIT_TX] = wr_flags && wbyte[0];

   assign hw_clr[7:3] = sw_clr[7:3];
   assign hw_clr[FLG_TX_DONE] = sw_clr[FLG_TX_BUF_EMPTY];
   assign hw_clr[FLG_MULTIPROC_BIT] = rx_acc && mp_fmt && !I_RX_MPB;
   assign hw_clr[FLG_MULTIPROC_BIT_TX] = wr_flags && !wbyte[0];

   // setting wins over a clear in the same cycle
   assign flags_d = (flags_q & ~hw_clr) | hw_set;

   always_ff @(posedge I_REF_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         flags_q <= FLAGS_RST;
         arm_q <= 8'h00;
      end
      else if (mod_clr)
      begin
         flags_q <= FLAGS_RST;
         arm_q <= 8'h00;
      end
      else
      begin
         flags_q <= flags_d;
         arm_q <= rd_flags ? (flags_q & FLG_CLR_MASK) :
            (wr_flags ? 8'h00 : arm_q);
      end
   end

   // rx buffer keeps its value when rx is disabled or on overrun
   always_ff @(posedge I_REF_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         rx_buf_q <= RXBUF_RST;
      end
      else if (mod_clr)
      begin
         rx_buf_q <= RXBUF_RST;
      end
      else if (rx_good || rx_fer || rx_per)
      begin
         rx_buf_q <= I_RX_DATA;
      end
   end

   // ---------------- datapath handshake ----------------
   assign O_TX_GO = tx_en && !flags_q[FLG_TX_BUF_EMPTY];
   assign O_TX_DATA = tx_buf_q;

   // ---------------- pin synchronisers ----------------
   logic [1:0] rxd_sync_q;
   logic [1:0] sck_sync_q;
   logic rxd_last_q;
   logic sck_last_q;
   always_ff @(posedge I_REF_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         // start at idle high so no false rising edge follows reset
         rxd_sync_q <= 2'h3;
         sck_sync_q <= 2'h3;
         rxd_last_q <= 1'b1;
         sck_last_q <= 1'b1;
      end
      else
      begin
         rxd_sync_q <= {rxd_sync_q[0], I_RXD};
         sck_sync_q <= {sck_sync_q[0], I_SCK_I};
         rxd_last_q <= rxd_sync_q[1];
         sck_last_q <= sck_sync_q[1];
      end
   end

   logic sck_rise;
   logic rxd_fall;
   logic rx_blocked;
   assign sck_rise = sck_sync_q[1] && !sck_last_q;
   assign rxd_fall = !rxd_sync_q[1] && rxd_last_q;
   // overrun and framing errors stop further reception until cleared
   assign rx_blocked = flags_q[FLG_OVERRUN_ERR] ||
      flags_q[FLG_FRAMING_ERR];
   assign O_EXT_CLK_EDGE = ext_clk && sck_rise;

   logic rx_begin_q;
   logic rx_begin_d;
   assign rx_begin_d = rx_en && !rx_blocked &&
      (sync_mode ? (ext_clk ? sck_rise : O_TX_GO) : rxd_fall);
   always_ff @(posedge I_REF_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         rx_begin_q <= 1'b0;
      end
      else
      begin
         rx_begin_q <= rx_begin_d;
      end
   end
   assign O_RX_BEGIN = rx_begin_q;

   // ---------------- internal bit clock and pin role ----------------
   logic [15:0] div_q;
   logic bit_clk_q;
   logic div_wrap;
   assign div_wrap = (div_q == 16'(HALF_BIT - 1));
   always_ff @(posedge I_REF_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         div_q <= 16'h0000;
         bit_clk_q <= 1'b1;
      end
      else if (div_wrap)
      begin
         div_q <= 16'h0000;
         bit_clk_q <= !bit_clk_q;
      end
      else
      begin
         div_q <= div_q + 16'h0001;
      end
   end

   logic pin_drive;
   logic pin_gpio;
   // out select only matters in async mode with internal clock
   assign pin_drive = !ext_clk &&
      (sync_mode || ctrl_q[CTL_CLK_PIN_OUT_SEL]);
   assign pin_gpio = !ext_clk && !sync_mode &&
      !ctrl_q[CTL_CLK_PIN_OUT_SEL];

   logic sck_o_q;
   logic sck_oe_q;
   logic sck_gpio_q;
   always_ff @(posedge I_REF_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         sck_o_q <= 1'b1;
         sck_oe_q <= 1'b0;
         sck_gpio_q <= 1'b1;
      end
      else
      begin
         sck_o_q <= bit_clk_q;
         sck_oe_q <= pin_drive;
         sck_gpio_q <= pin_gpio;
      end
   end
   assign O_SCK_O = sck_o_q;
   assign O_SCK_OE = sck_oe_q;
   assign O_SCK_GPIO = sck_gpio_q;

   // ---------------- interrupt request gating ----------------
   assign O_TX_EMPTY_IRQ = ctrl_q[CTL_TX_EMPTY_IRQ_EN] &&
      flags_q[FLG_TX_BUF_EMPTY];
   assign O_RX_FULL_IRQ = ctrl_q[CTL_RX_IRQ_EN] &&
      flags_q[FLG_RX_FULL];
   assign O_RX_ERR_IRQ = ctrl_q[CTL_RX_IRQ_EN] &&
      (flags_q[FLG_OVERRUN_ERR] || flags_q[FLG_FRAMING_ERR] ||
      flags_q[FLG_PARITY_ERR]);
   assign O_TX_DONE_IRQ = ctrl_q[CTL_TX_DONE_IRQ_EN] &&
      flags_q[FLG_TX_DONE];
endmodule : spcg_top
`default_nettype wire

/* verif/spcg_chk_assertions.sv */
// concurrent checks on the serial port control block ports
`timescale 1ns/1ps
`default_nettype none
module spcg_chk
(
   input wire logic I_REF_CLK,
   input wire logic I_RST_B,
   input wire logic I_STANDBY,
   input wire logic I_MODULE_STOP,
   input wire logic I_TX_LOAD,
   input wire logic I_TX_LAST_BIT,
   input wire logic I_RX_DONE,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic S_AXI_RVALID,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic O_TX_GO,
   input wire logic [7:0] O_TX_DATA,
   input wire logic O_SCK_OE,
   input wire logic O_SCK_GPIO,
   input wire logic O_TX_EMPTY_IRQ,
   input wire logic O_RX_FULL_IRQ,
   input wire logic O_RX_ERR_IRQ,
   input wire logic O_TX_DONE_IRQ
);
   default clocking cb @(posedge I_REF_CLK);
   endclocking
   default disable iff (!I_RST_B);
   a_standby_clear: assert property ((I_STANDBY || I_MODULE_STOP) |=>
      !(O_TX_EMPTY_IRQ || O_RX_FULL_IRQ || O_RX_ERR_IRQ || O_TX_DONE_IRQ
      || O_TX_GO) && O_TX_DATA == 8'hff) else $error("clear left state");
   a_load_sets_empty: assert property (I_TX_LOAD |=> !O_TX_GO)
      else $error("tx go after load");
   a_go_not_empty: assert property (O_TX_GO |-> !O_TX_EMPTY_IRQ)
      else $error("empty request while sending");
   a_txe_rise_cause: assert property ($rose(O_TX_EMPTY_IRQ) |->
      $past(I_TX_LOAD) || S_AXI_BVALID || $past(S_AXI_BVALID))
      else $error("tx empty request without cause");
   a_rx_rise_cause: assert property ($rose(O_RX_FULL_IRQ || O_RX_ERR_IRQ)
      |-> $past(I_RX_DONE) || S_AXI_BVALID || $past(S_AXI_BVALID))
      else $error("rx request without cause");
   a_done_rise_cause: assert property ($rose(O_TX_DONE_IRQ) |->
      $past(I_TX_LAST_BIT) || S_AXI_BVALID || $past(S_AXI_BVALID))
      else $error("tx done request without cause");
   a_pin_role: assert property (O_SCK_OE |-> !O_SCK_GPIO)
      else $error("pin driven while a port");
   a_rdata_upper: assert property (S_AXI_RVALID |->
      S_AXI_RDATA[31:8] == 24'h0) else $error("upper read bits set");
   a_bvalid_once: assert property (S_AXI_BVALID && S_AXI_BREADY |=>
      !S_AXI_BVALID) else $error("write answered twice");
endmodule : spcg_chk
`default_nettype wire

/* verif/spcg_far_model.sv */
// far side: remote transmitter and serial clock source
`timescale 1ns/1ps
`default_nettype none
module spcg_far_model
(
   output logic o_rxd,
   output logic o_sck
);
   localparam int BIT_NS = 64;
   // line idles at mark, clock stands still high between frames
   initial
   begin
      o_rxd = 1'b1;
      o_sck = 1'b1;
   end
   task automatic clocks(input int n);
      begin
         #3;
         repeat (n)
         begin
            #(BIT_NS / 2) o_sck = 1'b0;
            #(BIT_NS / 2) o_sck = 1'b1;
         end
      end
   endtask : clocks
   task automatic frame(input logic [7:0] d);
      int k;
      begin
         #3 o_rxd = 1'b0;
         for (k = 0; k < 8; k++)
            #(BIT_NS) o_rxd = d[k];
         #(BIT_NS) o_rxd = 1'b1;
         #(BIT_NS);
      end
   endtask : frame
endmodule : spcg_far_model
`default_nettype wire

/* verif/spcg_top_tb.sv */
// register-level bench for the serial port control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
   $display("unexpected at %0t: got %h want %h", $time, (g), (e)); end end
module spcg_top_tb
   import spcg_pkg::*;
;
   localparam int HALF = 4;
   logic clk, rst_b, standby, mstop, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, tx_go, rx_begin, ext_edge;
   logic sck_o, oe, gpio, txe_irq, rxf_irq, rxe_irq, done_irq, rxd, sck;
   logic tx_load, tx_last, rx_done, rx_mpb, rx_fe;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, wdata;
   logic [7:0] awaddr, araddr, tx_data, rx_data;
   int num_errors = 0, checks = 0, cyc = 0, n_edge = 0, n_begin = 0;
   spcg_top #(.HALF_BIT(HALF)) dut_u (.I_REF_CLK(clk), .I_RST_B(rst_b),
      .I_STANDBY(standby), .I_MODULE_STOP(mstop), .S_AXI_AWADDR(awaddr),
      .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .I_TX_LOAD(tx_load),
      .I_TX_LAST_BIT(tx_last), .I_RX_DONE(rx_done), .I_RX_DATA(rx_data),
      .I_RX_MPB(rx_mpb), .I_RX_FRAME_ERR(rx_fe), .I_RX_PARITY_ERR(rx_fe),
      .O_TX_GO(tx_go), .O_TX_DATA(tx_data), .O_RX_BEGIN(rx_begin),
      .O_EXT_CLK_EDGE(ext_edge), .I_RXD(rxd), .I_SCK_I(sck), .O_SCK_O(sck_o),
      .O_SCK_OE(oe), .O_SCK_GPIO(gpio), .O_TX_EMPTY_IRQ(txe_irq),
      .O_RX_FULL_IRQ(rxf_irq), .O_RX_ERR_IRQ(rxe_irq),
      .O_TX_DONE_IRQ(done_irq));
   spcg_far_model far_u (.o_rxd(rxd), .o_sck(sck));
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk)
   begin
      n_edge += ext_edge;
      n_begin += rx_begin;
      cyc++;
      if (cyc == 20000)
      begin
         num_errors++;
         complete_run();
      end
   end
   task automatic complete_run();
      begin
         $display("checks %0d mismatches %0d", checks, num_errors);
         if (num_errors == 0 && checks > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask : complete_run
   task automatic axi_wr(input logic [7:0] a, input logic [7:0] v,
      input logic [1:0] er);
      logic aw_done, w_done;
      begin
         aw_done = 1'b0;
         w_done = 1'b0;
         @(posedge clk);
         awaddr <= a;
         wdata <= {24'h0, v};
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         while (!(aw_done && w_done))
         begin
            @(posedge clk);
            if (awready === 1'b1 && !aw_done)
            begin
               aw_done = 1'b1;
               awvalid <= 1'b0;
            end
            if (wready === 1'b1 && !w_done)
            begin
               w_done = 1'b1;
               wvalid <= 1'b0;
            end
         end
         do @(posedge clk); while (bvalid !== 1'b1);
         bready <= 1'b0;
         `CHK(bresp, er);
      end
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
      begin
         @(posedge clk);
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         do @(posedge clk); while (arready !== 1'b1);
         arvalid <= 1'b0;
         do @(posedge clk); while (rvalid !== 1'b1);
         d = rdata;
         r = rresp;
         rready <= 1'b0;
      end
   endtask : axi_rd
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic [31:0] d;
      logic [1:0] r;
      begin
         axi_rd(a, d, r);
         `CHK({r, d}, {RESP_OKAY, 24'h0, e});
      end
   endtask : rd_chk
   task automatic ev(input logic ld, input logic lb, input logic rd,
      input logic [7:0] v, input logic multiproc_bit_flag, input logic fe);
      begin
         @(posedge clk);
         tx_load <= ld;
         tx_last <= lb;
         rx_done <= rd;
         rx_data <= v;
         rx_mpb <= multiproc_bit_flag;
         rx_fe <= fe;
         @(posedge clk);
         {tx_load, tx_last, rx_done} <= 3'h0;
         @(posedge clk);
      end
   endtask : ev
   initial
   begin : main
      logic [31:0] d;
      logic [1:0] r;
      logic s;
      int i, e0, b0;
      {rst_b, standby, mstop, awvalid, wvalid, bready} = 6'h0;
      {arvalid, rready, tx_load, tx_last, rx_done, rx_mpb, rx_fe} = 7'h0;
      {awaddr, araddr, rx_data, wdata} = 56'h0;
      repeat (10) @(posedge clk);
      `CHK(gpio, 1'b1);
      rst_b <= 1'b1;
      rd_chk(ADDR_CTRL, 8'h00);
      rd_chk(ADDR_FLAGS, 8'h84);
      rd_chk(ADDR_TXBUF, 8'hff);
      axi_rd(8'h20, d, r);
      `CHK({r, d}, {RESP_DECERR, 32'h0});
      axi_wr(8'h20, 8'h00, RESP_DECERR);
      for (i = 0; i < 8; i++)
      begin
         axi_wr(ADDR_CTRL, 8'h01 << i, RESP_OKAY);
         rd_chk(ADDR_CTRL, 8'h01 << i);
      end
      $display("test reset and access done");
      axi_wr(ADDR_FMT, 8'h00, RESP_OKAY);
      axi_wr(ADDR_CTRL, 8'ha0, RESP_OKAY);
      `CHK(txe_irq, 1'b1);
      axi_rd(ADDR_FLAGS, d, r);
      axi_wr(ADDR_TXBUF, 8'h3c, RESP_OKAY);
      axi_wr(ADDR_FLAGS, 8'h7f, RESP_OKAY);
      `CHK({txe_irq, tx_go, tx_data}, {2'b01, 8'h3c});
      ev(1'b1, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
      `CHK({txe_irq, tx_go}, 2'b10);
      axi_wr(ADDR_FLAGS, 8'h7f, RESP_OKAY);
      `CHK(txe_irq, 1'b1);
      axi_wr(ADDR_CTRL, 8'h24, RESP_OKAY);
      `CHK({txe_irq, done_irq}, 2'b00);
      ev(1'b0, 1'b1, 1'b0, 8'h00, 1'b0, 1'b0);
      `CHK(done_irq, 1'b1);
      axi_rd(ADDR_FLAGS, d, r);
      axi_wr(ADDR_FLAGS, 8'h7f, RESP_OKAY);
      `CHK(done_irq, 1'b0);
      axi_wr(ADDR_CTRL, 8'h00, RESP_OKAY);
      axi_rd(ADDR_FLAGS, d, r);
      `CHK(d[7], 1'b1);
      $display("test transmit done");
      axi_wr(ADDR_CTRL, 8'h50, RESP_OKAY);
      ev(1'b0, 1'b0, 1'b1, 8'h5a, 1'b0, 1'b0);
      `CHK({rxf_irq, rxe_irq}, 2'b10);
      ev(1'b0, 1'b0, 1'b1, 8'ha5, 1'b0, 1'b0);
      `CHK(rxe_irq, 1'b1);
      rd_chk(ADDR_RXBUF, 8'h5a);
      axi_wr(ADDR_CTRL, 8'h40, RESP_OKAY);
      axi_rd(ADDR_FLAGS, d, r);
      `CHK({d[6:5], rxf_irq, rxe_irq}, 4'hf);
      axi_wr(ADDR_CTRL, 8'h00, RESP_OKAY);
      `CHK({rxf_irq, rxe_irq}, 2'b00);
      axi_wr(ADDR_CTRL, 8'h50, RESP_OKAY);
      `CHK({rxf_irq, rxe_irq}, 2'b11);
      axi_wr(ADDR_FLAGS, 8'h87, RESP_OKAY);
      `CHK({rxf_irq, rxe_irq}, 2'b00);
      ev(1'b0, 1'b0, 1'b1, 8'h77, 1'b0, 1'b1);
      `CHK({rxf_irq, rxe_irq}, 2'b01);
      axi_rd(ADDR_FLAGS, d, r);
      `CHK(d[4:3], 2'b11);
      axi_wr(ADDR_FLAGS, 8'h87, RESP_OKAY);
      `CHK(rxe_irq, 1'b0);
      $display("test receive done");
      axi_wr(ADDR_FMT, 8'h04, RESP_OKAY);
      axi_wr(ADDR_CTRL, 8'h58, RESP_OKAY);
      ev(1'b0, 1'b0, 1'b1, 8'h11, 1'b0, 1'b0);
      `CHK(rxf_irq, 1'b0);
      rd_chk(ADDR_RXBUF, 8'h77);
      ev(1'b0, 1'b0, 1'b1, 8'h22, 1'b1, 1'b0);
      `CHK(rxf_irq, 1'b1);
      rd_chk(ADDR_CTRL, 8'h50);
      axi_rd(ADDR_FLAGS, d, r);
      `CHK(d[1], 1'b1);
      axi_wr(ADDR_FLAGS, 8'h87, RESP_OKAY);
      axi_wr(ADDR_FMT, 8'h84, RESP_OKAY);
      axi_wr(ADDR_CTRL, 8'h58, RESP_OKAY);
      ev(1'b0, 1'b0, 1'b1, 8'h33, 1'b0, 1'b0);
      rd_chk(ADDR_RXBUF, 8'h33);
      axi_rd(ADDR_FLAGS, d, r);
      axi_wr(ADDR_FLAGS, 8'h87, RESP_OKAY);
      $display("test multiprocessor done");
      for (i = 0; i < 8; i++)
      begin
         axi_wr(ADDR_FMT, {i[2], 7'h0}, RESP_OKAY);
         axi_wr(ADDR_CTRL, {6'h0, i[1:0]}, RESP_OKAY);
         repeat (2) @(posedge clk);
         `CHK({oe, gpio}, {~i[1] & (i[2] | i[0]), ~(i[2] | i[1] | i[0])});
         s = sck_o;
         repeat (HALF) @(posedge clk);
         if (i == 1)
            `CHK(sck_o, ~s);
      end
      axi_wr(ADDR_FMT, 8'h80, RESP_OKAY);
      axi_wr(ADDR_CTRL, 8'h12, RESP_OKAY);
      e0 = n_edge;
      b0 = n_begin;
      far_u.clocks(4);
      repeat (6) @(posedge clk);
      `CHK(n_edge - e0, 4);
      `CHK(n_begin - b0, 4);
      axi_wr(ADDR_FMT, 8'h00, RESP_OKAY);
      axi_wr(ADDR_CTRL, 8'h10, RESP_OKAY);
      b0 = n_begin;
      far_u.frame(8'hff);
      repeat (6) @(posedge clk);
      `CHK(n_begin - b0, 1);
      $display("test clock pin and link done");
      for (i = 0; i < 2; i++)
      begin
         axi_wr(ADDR_FMT, 8'h84, RESP_OKAY);
         axi_wr(ADDR_CTRL, 8'ha4, RESP_OKAY);
         axi_wr(ADDR_TXBUF, 8'h12, RESP_OKAY);
         @(posedge clk);
         standby <= (i == 0);
         mstop <= (i == 1);
         @(posedge clk);
         standby <= 1'b0;
         mstop <= 1'b0;
         rd_chk(ADDR_CTRL, 8'h00);
         rd_chk(ADDR_FMT, 8'h00);
         rd_chk(ADDR_FLAGS, 8'h84);
         rd_chk(ADDR_TXBUF, 8'hff);
      end
      $display("test standby done");
      complete_run();
   end
endmodule : spcg_top_tb
bind spcg_top spcg_chk chk_u (.I_REF_CLK, .I_RST_B, .I_STANDBY,
   .I_MODULE_STOP, .I_TX_LOAD, .I_TX_LAST_BIT, .I_RX_DONE, .S_AXI_BVALID,
   .S_AXI_BREADY, .S_AXI_RVALID, .S_AXI_RDATA, .O_TX_GO, .O_TX_DATA,
   .O_SCK_OE, .O_SCK_GPIO, .O_TX_EMPTY_IRQ, .O_RX_FULL_IRQ, .O_RX_ERR_IRQ,
   .O_TX_DONE_IRQ);
`default_nettype wire
